// >>> include/tpl_pkg.sv
// Shared constants and types for the token-passing link access block.
// Assumes a single 25 MHz system clock drives everything.
package tpl_pkg;
   // Clock rate and link bit rate
   localparam int TPL_CLK_MHZ = 25;
   localparam int TPL_BIT_RATE = 57600;
   localparam int TPL_BIT_CYC = (TPL_CLK_MHZ * 1000000) / TPL_BIT_RATE;
   // Token hold window, in microseconds and cycles
   localparam int TPL_TMIN_US = 1500;
   localparam int TPL_TMAX_US = 38000;
   localparam int TPL_TMIN_CYC = TPL_TMIN_US * TPL_CLK_MHZ;
   localparam int TPL_TMAX_CYC = TPL_TMAX_US * TPL_CLK_MHZ;
   // Silence before the token counts as lost, and per-station claim slot
   localparam int TPL_LOSS_US = 100000;
   localparam int TPL_SLOT_US = 1000;
   localparam int TPL_LOSS_CYC = TPL_LOSS_US * TPL_CLK_MHZ;
   localparam int TPL_SLOT_CYC = TPL_SLOT_US * TPL_CLK_MHZ;
   // Link sizes
   localparam int TPL_MAX_BYTES = 271;
   localparam int TPL_STATIONS = 64;
   localparam int TPL_STN_W = 6;
   localparam int TPL_BYTE_W = 8;
   localparam int TPL_FIFO_DEPTH = 8;
   localparam int TPL_FIFO_W = TPL_BYTE_W + 1;

   typedef enum logic [1:0] {
      TPL_IDLE = 2'h0,
      TPL_SEND = 2'h1,
      TPL_FLUSH = 2'h3,
      TPL_PASS = 2'h2
   } tpl_state_t;
endpackage : tpl_pkg

// >>> core/tpl_fifo.sv
// First-in first-out buffer with valid/ready on both sides.
// Assumes DEPTH is a power of two; in_ready comes from a flip-flop.
`timescale 1ns/1ps
module tpl_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Fill side
   input wire logic in_valid,
   input wire logic [WIDTH-1:0] in_data,
   output logic in_ready,
   // Drain side
   output logic out_valid,
   output logic [WIDTH-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("tpl_fifo: DEPTH must be a power of two of at least 2");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   logic [AW:0] count_next;
   logic push;
   logic pop;

   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = count_reg != '0;
   assign out_data = mem[rd_ptr_reg];
   assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);

   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
         in_ready <= 1'b0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + AW'(push);
         rd_ptr_reg <= rd_ptr_reg + AW'(pop);
         count_reg <= count_next;
         in_ready <= count_next != (AW+1)'(DEPTH);
      end
   end
endmodule : tpl_fifo

// >>> core/tpl_access.sv
// Medium-access logic of one station on a token-passing multi-drop link.
// Assumes a framer below that sends tx bytes at the bit tick and reports
// token frames addressed to this station and any activity seen on the link.
`timescale 1ns/1ps
module tpl_access
   import tpl_pkg::*;
#(
   parameter int TMIN_CYC = tpl_pkg::TPL_TMIN_CYC,
   parameter int TMAX_CYC = tpl_pkg::TPL_TMAX_CYC,
   parameter int LOSS_CYC = tpl_pkg::TPL_LOSS_CYC,
   parameter int SLOT_CYC = tpl_pkg::TPL_SLOT_CYC,
   parameter int MAX_BYTES = tpl_pkg::TPL_MAX_BYTES,
   parameter int FIFO_DEPTH = tpl_pkg::TPL_FIFO_DEPTH
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Station setup
   input wire logic [tpl_pkg::TPL_STN_W-1:0] station_id,
   input wire logic [tpl_pkg::TPL_STATIONS-1:0] active_map,
   // Link events
   input wire logic token_rx,
   input wire logic link_activity,
   // Message queue
   input wire logic q_valid,
   input wire logic [tpl_pkg::TPL_BYTE_W-1:0] q_data,
   input wire logic q_last,
   output logic q_ready,
   // Transmit stream
   output logic tx_valid,
   output logic [tpl_pkg::TPL_BYTE_W-1:0] tx_data,
   output logic tx_last,
   input wire logic tx_ready,
   output logic bit_tick,
   // Token status
   output logic token_pass,
   output logic [tpl_pkg::TPL_STN_W-1:0] token_dest,
   output logic token_held,
   output logic token_lost
);
   import tpl_pkg::*;

   localparam int HW = $clog2(TMAX_CYC + 1);
   localparam int BW = $clog2(MAX_BYTES + 1);
   localparam int LW = $clog2(LOSS_CYC + TPL_STATIONS * SLOT_CYC + 1);
   localparam int KW = $clog2(TPL_BIT_CYC);

   if (TMIN_CYC < 1 || TMIN_CYC > TMAX_CYC || MAX_BYTES < 1 || SLOT_CYC < 1) begin : g_chk
      $error("tpl_access: hold window, byte budget or slot length out of range");
   end

   // Next higher active station, wrapping; itself when alone
   function automatic logic [TPL_STN_W-1:0] next_station(input logic [TPL_STN_W-1:0] own,
                                                        input logic [TPL_STATIONS-1:0] map);
      logic [TPL_STN_W-1:0] cand;
      logic found;
      next_station = own;
      found = 1'b0;
      for (int i = 1; i < TPL_STATIONS; i++) begin
         cand = own + TPL_STN_W'(i);
         if (!found && map[cand]) begin
            next_station = cand;
            found = 1'b1;
         end
      end
   endfunction : next_station

   tpl_state_t state_reg;
   logic [HW-1:0] hold_cnt_reg;
   logic [BW-1:0] byte_cnt_reg;
   logic at_boundary_reg;
   logic [LW-1:0] idle_cnt_reg;
   logic [KW-1:0] bit_cnt_reg;
   logic f_valid;
   logic [TPL_FIFO_W-1:0] f_data;
   logic can_load;
   logic start_ok;
   logic load;
   logic seg_end;
   logic done;
   logic claim;
   logic [LW-1:0] claim_at;

   tpl_fifo #(
      .WIDTH(TPL_FIFO_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(core_clk),
      .rst_n(rst_n),
      .in_valid(q_valid),
      .in_data({q_last, q_data}),
      .in_ready(q_ready),
      .out_valid(f_valid),
      .out_data(f_data),
      .out_ready(load)
   );

   assign can_load = !tx_valid || tx_ready;
   assign start_ok = !at_boundary_reg || (hold_cnt_reg < HW'(TMAX_CYC));
   // Head of queue only, so order of messages and replies is kept
   assign load = (state_reg == TPL_SEND) && can_load && f_valid && start_ok
                 && (byte_cnt_reg < BW'(MAX_BYTES));
   assign seg_end = f_data[TPL_BYTE_W] || (byte_cnt_reg == BW'(MAX_BYTES - 1))
                    || (hold_cnt_reg >= HW'(TMAX_CYC));
   // Empty queue at a message boundary ends the turn once the least hold is met
   assign done = at_boundary_reg && !load && (hold_cnt_reg >= HW'(TMIN_CYC))
                 && ((byte_cnt_reg == BW'(MAX_BYTES)) || (hold_cnt_reg >= HW'(TMAX_CYC))
                 || !f_valid);
   assign claim_at = LW'(LOSS_CYC) + LW'(station_id) * LW'(SLOT_CYC);
   assign claim = (state_reg == TPL_IDLE) && (idle_cnt_reg == claim_at);

   // Access sequencing
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= TPL_IDLE;
      end else begin
         case (state_reg)
            TPL_IDLE: begin
               if (token_rx || claim) begin
                  state_reg <= TPL_SEND;
               end
            end
            TPL_SEND: begin
               if (done) begin
                  state_reg <= TPL_FLUSH;
               end
            end
            TPL_FLUSH: begin
               if (can_load) begin
                  state_reg <= TPL_PASS;
               end
            end
            TPL_PASS: state_reg <= TPL_IDLE;
            default: state_reg <= TPL_IDLE;
         endcase
      end
   end

   // Hold timer, byte budget and message boundary
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt_reg <= '0;
         byte_cnt_reg <= '0;
         at_boundary_reg <= 1'b1;
      end else if (state_reg == TPL_IDLE) begin
         hold_cnt_reg <= '0;
         byte_cnt_reg <= '0;
      end else begin
         if (hold_cnt_reg < HW'(TMAX_CYC)) begin
            hold_cnt_reg <= hold_cnt_reg + HW'(1);
         end
         if (load) begin
            byte_cnt_reg <= byte_cnt_reg + BW'(1);
            at_boundary_reg <= seg_end;
         end
      end
   end

   // Transmit holding register
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_valid <= 1'b0;
         tx_data <= '0;
         tx_last <= 1'b0;
      end else if (load) begin
         tx_valid <= 1'b1;
         tx_data <= f_data[TPL_BYTE_W-1:0];
         tx_last <= seg_end;
      end else if (tx_ready) begin
         tx_valid <= 1'b0;
      end
   end

   // Token hand-off
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         token_pass <= 1'b0;
         token_dest <= '0;
         token_held <= 1'b0;
      end else begin
         token_pass <= (state_reg == TPL_FLUSH) && can_load;
         if ((state_reg == TPL_FLUSH) && can_load) begin
            token_dest <= next_station(station_id, active_map);
         end
         if ((state_reg == TPL_IDLE) && (token_rx || claim)) begin
            token_held <= 1'b1;
         end else if (state_reg == TPL_PASS) begin
            token_held <= 1'b0;
         end
      end
   end

   // Silence watch and loss flag; a new loss wins over a clear
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         idle_cnt_reg <= '0;
         token_lost <= 1'b0;
      end else begin
         if (link_activity || token_rx || (state_reg != TPL_IDLE)) begin
            idle_cnt_reg <= '0;
         end else if (idle_cnt_reg != '1) begin
            idle_cnt_reg <= idle_cnt_reg + LW'(1);
         end
         if ((state_reg == TPL_IDLE) && (idle_cnt_reg >= LW'(LOSS_CYC))) begin
            token_lost <= 1'b1;
         end else if (token_rx || token_pass) begin
            token_lost <= 1'b0;
         end
      end
   end

   // Bit pacing for the line driver
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_reg <= '0;
         bit_tick <= 1'b0;
      end else begin
         bit_tick <= bit_cnt_reg == KW'(TPL_BIT_CYC - 1);
         if (bit_cnt_reg == KW'(TPL_BIT_CYC - 1)) begin
            bit_cnt_reg <= '0;
         end else begin
            bit_cnt_reg <= bit_cnt_reg + KW'(1);
         end
      end
   end

   logic has_above;
   assign has_above = |(active_map & ~((64'h2 << station_id) - 64'h1));

   AST_SILENT: assert property (@(posedge core_clk) disable iff (!rst_n)
      tx_valid |-> token_held && (state_reg != TPL_IDLE))
      else $error("transmit offered without token");

   AST_DEST_ACTIVE: assert property (@(posedge core_clk) disable iff (!rst_n)
      token_pass |-> active_map[token_dest] || (token_dest == station_id))
      else $error("token passed to inactive station");

   AST_MIN_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      token_pass |-> hold_cnt_reg >= HW'(TMIN_CYC))
      else $error("token passed before least hold time");

   AST_BYTE_BUDGET: assert property (@(posedge core_clk) disable iff (!rst_n)
      (tx_valid && !$past(tx_valid)) |-> byte_cnt_reg <= BW'(MAX_BYTES) && byte_cnt_reg != '0)
      else $error("byte budget exceeded");

   AST_SPLIT: assert property (@(posedge core_clk) disable iff (!rst_n)
      (load && byte_cnt_reg == BW'(MAX_BYTES - 1)) |=> tx_last && tx_valid)
      else $error("segment not closed at byte budget");

   AST_WRAP: assert property (@(posedge core_clk) disable iff (!rst_n)
      (token_pass && has_above) |-> token_dest > station_id)
      else $error("token skipped a higher station");

   AST_LATE_START: assert property (@(posedge core_clk) disable iff (!rst_n)
      (load && at_boundary_reg) |-> hold_cnt_reg < HW'(TMAX_CYC))
      else $error("message started past hold limit");

   AST_LOSS_FLAG: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_reg == TPL_IDLE && idle_cnt_reg >= LW'(LOSS_CYC)) |=> token_lost)
      else $error("token loss not flagged");

   AST_PASS_PULSE: assert property (@(posedge core_clk) disable iff (!rst_n)
      token_pass |=> !token_pass && !token_held)
      else $error("token hand-off not a single pulse");
endmodule : tpl_access

// >>> bench/tpl_peer.sv
// Far side of the station: the framer that takes bytes and the peers that hand over the token.
// Assumes give() is called just after a falling edge of core_clk.
`timescale 1ns/1ps
module tpl_peer (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Byte stream
   output logic tx_ready,
   // Link events
   output logic token_rx,
   output logic link_activity
);
   initial begin
      tx_ready = 1'b0;
      token_rx = 1'b0;
      link_activity = 1'b0;
   end
   // Framer stalls at random, like a line still shifting out bits
   always @(negedge core_clk) tx_ready <= rst_n && ($urandom % 4 != 0);
   // A peer ends its turn by addressing the token to us
   task automatic give();
      token_rx = 1'b1;
      link_activity = 1'b1;
      @(negedge core_clk);
      token_rx = 1'b0;
      link_activity = 1'b0;
   endtask : give
endmodule : tpl_peer

// >>> bench/tb.sv
// Self-checking bench for the station access block with shortened hold and loss counts.
// Assumes the peer model drives the framer ready and token events.
`timescale 1ns/1ps
module tb;
   import tpl_pkg::*;
   localparam int TMIN = 20;
   localparam int TMAX = 1000;
   localparam int LOSS = 300;
   localparam int SLOT = 10;
   localparam logic [5:0] ID = 6'h05;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic q_valid = 1'b0;
   logic q_last = 1'b0;
   logic [7:0] q_data = 8'h00;
   logic [63:0] active_map = 64'h0;
   logic q_ready, tx_valid, tx_last, tx_ready, bit_tick, token_pass, token_held, token_lost, token_rx, link_activity;
   logic [7:0] tx_data;
   logic [5:0] token_dest;
   logic took = 1'b0;
   logic pause = 1'b0;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   int hold = 0;
   int nbytes = 0;
   int max_bytes = 0;
   logic [8:0] src_q[$];
   logic [7:0] exp_q[$];
   logic lst_q[$];
   logic [63:0] maps[6] = '{64'h0, 64'h220, 64'h24, 64'h8000_0000_0000_0020, '1, 64'h0};

   tpl_access #(.TMIN_CYC(TMIN), .TMAX_CYC(TMAX), .LOSS_CYC(LOSS), .SLOT_CYC(SLOT), .MAX_BYTES(271),
      .FIFO_DEPTH(8)) dut (.core_clk(core_clk), .rst_n(rst_n), .station_id(ID), .active_map(active_map),
      .token_rx(token_rx), .link_activity(link_activity), .q_valid(q_valid), .q_data(q_data), .q_last(q_last),
      .q_ready(q_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
      .bit_tick(bit_tick), .token_pass(token_pass), .token_dest(token_dest), .token_held(token_held),
      .token_lost(token_lost));
   tpl_peer peer (.core_clk(core_clk), .rst_n(rst_n), .tx_ready(tx_ready), .token_rx(token_rx),
      .link_activity(link_activity));

   initial forever #20 core_clk = ~core_clk;

   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask : check

   task automatic results();
      $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results

   // Next higher active station, wrapping; alone means ourselves
   function automatic logic [5:0] succ(input logic [63:0] m);
      for (int i = 1; i < 64; i++) if (m[(ID + i) % 64]) return 6'((ID + i) % 64);
      return ID;
   endfunction : succ

   task automatic add_msg(input int n);
      logic [7:0] b;
      for (int i = 0; i < n; i++) begin
         b = 8'($urandom);
         src_q.push_back({i == n - 1, b});
         exp_q.push_back(b);
         lst_q.push_back(i == n - 1);
      end
   endtask : add_msg

   task automatic turn(input logic do_give);
      int k;
      if (do_give) peer.give();
      for (k = 0; k < TMAX + 400 && token_pass !== 1'b1; k++) @(negedge core_clk);
      check(token_pass === 1'b1, "token not passed on");
      @(negedge core_clk);
   endtask : turn

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         error_cnt++;
         $display("Error at %0t: run hung", $time);
         results();
      end
   end

   // Queue source: present the oldest byte, drop it once taken
   always @(posedge core_clk) took <= q_valid && q_ready;
   always @(negedge core_clk) begin
      if (took) void'(src_q.pop_front());
      q_valid <= src_q.size() > 0 && !pause;
      {q_last, q_data} <= src_q.size() > 0 ? src_q[0] : 9'($urandom);
   end

   // Reference model of the transmit stream and token hand-over
   always @(posedge core_clk) if (rst_n) begin
      hold = token_held ? hold + 1 : 0;
      if (tx_valid && tx_ready) begin
         check(token_held === 1'b1, "byte sent without token");
         check(exp_q.size() > 0 && tx_data === exp_q[0], "byte out of order");
         nbytes++;
         // Segment ends at message end, at the byte budget, or at the first byte past the hold limit
         check(exp_q.size() > 0 && tx_last === (lst_q[0] || nbytes == 271 || hold >= TMAX),
               "segment end misplaced");
         if (exp_q.size() > 0) begin
            void'(exp_q.pop_front());
            void'(lst_q.pop_front());
         end
      end
      if (token_pass) begin
         check(nbytes <= 271, "byte budget exceeded");
         check(token_dest === succ(active_map), "wrong successor");
         check(hold >= TMIN && hold <= TMAX + 20, "hold time out of window");
         if (nbytes > max_bytes) max_bytes = nbytes;
         nbytes = 0;
      end
   end

   initial begin
      int t;
      int k;
      void'($urandom(76));
      repeat (3) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge core_clk);
      check(q_ready === 1'b1 && token_held === 1'b0 && tx_valid === 1'b0 && token_lost === 1'b0, "reset state");
      @(posedge bit_tick);
      t = cyc;
      @(posedge bit_tick);
      check(cyc - t == 434, "bit pacing period");
      // Back to the falling edge so that the token event spans a rising edge
      @(negedge core_clk);
      maps[5] = {$urandom, $urandom};
      foreach (maps[i]) begin
         active_map = maps[i];
         turn(1'b1);
      end
      // One over-long message ahead of short ones, buffer filled before the turn
      active_map = 64'h124;
      add_msg(300);
      repeat (3) add_msg(1 + $urandom % 20);
      repeat (14) @(negedge core_clk);
      check(q_ready === 1'b0, "full buffer still accepts");
      for (k = 0; k < 8 && exp_q.size() > 0; k++) turn(1'b1);
      check(exp_q.size() == 0, "queued messages not delivered");
      check(max_bytes == 271, "long message not cut at limit");
      // Source stalls mid-message until the hold limit: the segment is cut, the rest follows next turn
      add_msg(40);
      repeat (4) @(negedge core_clk);
      pause = 1'b1;
      fork
         turn(1'b1);
         begin
            wait (hold >= TMAX);
            @(negedge core_clk);
            pause = 1'b0;
         end
      join
      check(exp_q.size() > 0, "message not cut at hold limit");
      turn(1'b1);
      check(exp_q.size() == 0, "cut message not completed");
      // Silence until loss is flagged and the station claims the token in its slot
      t = cyc;
      for (k = 0; k < LOSS + 50 && token_lost !== 1'b1; k++) @(negedge core_clk);
      check(cyc - t >= LOSS - 3 && cyc - t <= LOSS + 3, "loss detect time");
      for (k = 0; k < ID * SLOT + 50 && token_held !== 1'b1; k++) @(negedge core_clk);
      check(cyc - t >= LOSS + ID * SLOT - 3 && cyc - t <= LOSS + ID * SLOT + 4, "claim slot");
      turn(1'b0);
      check(token_lost === 1'b0, "loss flag kept after pass");
      results();
   end
endmodule : tb
